//--- fbi_pkg.sv
// Package for the flash bus interface and command front end.
package fbi_pkg;

  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int PART_MSB = 23;
  localparam int PART_LSB = 21;
  localparam int NUM_PART = 8;

  // Command codes as written on the data pins.
  localparam logic [15:0] CMD_CFG_SETUP = 16'h0060;
  localparam logic [15:0] CMD_CFG_RCR = 16'h0003;
  localparam logic [15:0] CMD_CFG_ECR = 16'h0004;
  localparam logic [15:0] CMD_LOCK = 16'h0001;
  localparam logic [15:0] CMD_LOCKDOWN = 16'h002f;
  localparam logic [15:0] CMD_CONFIRM = 16'h00d0;
  localparam logic [15:0] CMD_OTP = 16'h00c0;
  localparam logic [15:0] CMD_CLR_STATUS = 16'h0050;
  localparam logic [15:0] CMD_RD_ARRAY = 16'h00ff;
  localparam logic [15:0] CMD_RD_STATUS = 16'h0070;
  localparam logic [15:0] CMD_RD_ID = 16'h0090;
  localparam logic [15:0] CMD_RD_CFI = 16'h0098;
  localparam logic [15:0] CMD_WORD_PROG = 16'h0041;
  localparam logic [15:0] CMD_BUF_SETUP = 16'h00e9;

  // Read configuration register layout and value after reset.
  localparam int RCR_MODE_BIT = 15;
  localparam int RCR_LAT_MSB = 14;
  localparam int RCR_LAT_LSB = 11;
  localparam int RCR_WAITPOL_BIT = 10;
  localparam int RCR_WRAP_BIT = 3;
  localparam int RCR_LEN_MSB = 2;
  localparam logic [15:0] RCR_RESET = 16'h9807;
  localparam logic [15:0] ECR_RESET = 16'h0000;
  localparam logic [2:0] BL_8 = 3'h2;
  localparam logic [2:0] BL_CONT = 3'h7;
  localparam logic [4:0] LEN_8 = 5'h08;
  localparam logic [4:0] LEN_16 = 5'h10;

  // Status word bit positions.
  localparam int SR_READY_BIT = 7;
  localparam int SR_ESEQ_BIT = 5;
  localparam int SR_EPROG_BIT = 4;

  typedef enum logic [4:0] {
    PEND_NONE = 5'h01,
    PEND_CFG = 5'h02,
    PEND_WORD = 5'h04,
    PEND_OTP = 5'h08,
    PEND_BUF = 5'h10
  } fbi_pend_e;

  typedef enum logic [3:0] {
    RM_ARRAY = 4'h1,
    RM_STATUS = 4'h2,
    RM_ID = 4'h4,
    RM_CFI = 4'h8
  } fbi_rmode_e;

  typedef struct packed {
    logic resetN;
    logic chipSelectN;
    logic outputEnableN;
    logic writeEnableN;
    logic addressValidN;
    logic burstClk;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] dataIn;
  } fbi_bus_in_s;

  typedef struct packed {
    logic [DATA_W-1:0] dataOut;
    logic dataOe;
    logic waitOut;
    logic waitOe;
  } fbi_pin_out_s;

  typedef struct packed {
    logic req;
    logic otp;
    logic bufData;
    logic bufStart;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fbi_prog_s;

  typedef struct packed {
    fbi_pin_out_s pins;
    fbi_prog_s prog;
    logic [ADDR_W-1:0] readAddr;
    logic [15:0] read_config_register;
    logic [15:0] ecr;
    logic [15:0] statusWord;
    logic lowPower;
    logic abortOp;
    fbi_pend_e cmdPend;
    fbi_rmode_e [NUM_PART-1:0] partMode;
    logic errSeq;
    logic errProg;
    logic clkPrev;
    logic advPrev;
    logic wrPrev;
    logic [ADDR_W-1:0] addrHold;
    logic [ADDR_W-1:0] wrAddr;
    logic [DATA_W-1:0] wrData;
    logic advUsed;
    logic bActive;
    logic bStartOdd;
    logic eowDone;
    logic [ADDR_W-1:0] bAddr;
    logic [3:0] latCnt;
    logic [3:0] eowCnt;
    logic [4:0] bRemain;
  } fbi_state_s;

endpackage

//--- fbi_flash_bus.sv
// Flash bus interface: read paths, write capture and command decoder.
// Summary of operation
// - Chip select high with reset released: standby, inputs ignored, outputs off.
// - Standby never stops a running program or erase; idle power waits for it.
// - Output enable high: data off; wait driven deasserted muxed, off otherwise.
// - Mode bit set: select plus output enable low gives asynchronous read.
// - Page reads give a new word whenever the low four address bits change.
// - Mode bit clear: select, output enable and address valid low give burst read.
// - First word after latency; array words advance, non-array words repeat.
// - Burst address latches on first edge or valid rise; fast grade on last edge.
// - Wrap bit chooses wrap within wordgroup or continue to the next one.
// - Burst starts at the addressed word and runs sequentially to its length.
// - Unaligned burst crossing a wordline stalls once, latency minus one, on wait.
// - Write captures address and data when write enable or select rises first.
// - Muxed writes latch address on valid or select rise, data on write end.
// - Read cycles may fall between setup and confirm of a two-cycle command.
// - After configuration setup, any code but 0003h, 0004h, 0001h, 002Fh or 00D0h sets sequence error bits.
// - Setup 0060h then 0003h or 0004h loads a configuration word from address.
// - Code 00C0h makes the next write program the one-time area.
// - Code 0050h clears all status error bits.
// - Read mode codes pick array, status, identity or query data per partition.
// - Word and buffered program requests switch the partition to status reads.
// - Reset pin low: inputs ignored, outputs off, running operation aborted.
`timescale 1ns/1ps
module fbi_flash_bus
  import fbi_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Flash bus pins and straps
  input wire fbi_bus_in_s busIn,
  input wire logic muxedBus,
  input wire logic fastGrade,
  output fbi_pin_out_s pinOut,
  // Array and information sources
  output logic [ADDR_W-1:0] readAddr,
  input wire logic [DATA_W-1:0] arrayData,
  input wire logic [DATA_W-1:0] idData,
  input wire logic [DATA_W-1:0] cfiData,
  // Program engine
  input wire logic opBusy,
  input wire logic progError,
  output fbi_prog_s prog,
  output logic abortOp,
  // Configuration and status
  output logic [15:0] readConfig,
  output logic [15:0] extConfig,
  output logic [15:0] statusWord,
  output logic lowPower
);

  fbi_state_s state_reg;
  fbi_state_s state_next;

  function automatic fbi_state_s rst_state();
    fbi_state_s r;
    r = '0;
    r.cmdPend = PEND_NONE;
    for (int i = 0; i < NUM_PART; i++) begin
      r.partMode[i] = RM_ARRAY;
    end
    r.read_config_register = RCR_RESET;
    r.ecr = ECR_RESET;
    r.advPrev = 1'b1;
    return r;
  endfunction

  always_comb begin
    fbi_state_s s;
    fbi_state_s n;
    fbi_bus_in_s b;
    logic [ADDR_W-1:0] curAddr;
    logic [ADDR_W-1:0] rdAddr;
    logic [ADDR_W-1:0] nextAddr;
    logic [DATA_W-1:0] srcData;
    logic [DATA_W-1:0] code;
    logic [2:0] pa;
    logic [2:0] bl;
    logic [3:0] lat;
    fbi_rmode_e srcMode;
    logic clkRise;
    logic advRise;
    logic wrAct;
    logic wrEnd;
    logic rdSel;
    logic syncMode;
    logic cont;
    logic noWrap;
    logic latchClk;
    logic latchAdv;
    logic waitAct;
    s = state_reg;
    n = state_reg;
    b = busIn;
    n.prog.req = 1'b0;
    n.prog.bufData = 1'b0;
    n.prog.bufStart = 1'b0;
    curAddr = muxedBus ? {b.address[ADDR_W-1:16], b.dataIn} : b.address;
    rdAddr = !b.addressValidN ? curAddr : s.addrHold;
    clkRise = b.burstClk & !s.clkPrev;
    advRise = b.addressValidN & !s.advPrev;
    wrAct = !b.chipSelectN & !b.writeEnableN & b.outputEnableN;
    wrEnd = s.wrPrev & !wrAct;
    rdSel = !b.chipSelectN & !b.outputEnableN & b.writeEnableN;
    syncMode = !s.read_config_register[RCR_MODE_BIT];
    bl = s.read_config_register[RCR_LEN_MSB:0];
    cont = (bl == BL_CONT);
    noWrap = s.read_config_register[RCR_WRAP_BIT] | cont;
    lat = (s.read_config_register[RCR_LAT_MSB:RCR_LAT_LSB] == 4'h0) ? 4'h1 : s.read_config_register[RCR_LAT_MSB:RCR_LAT_LSB];
    code = s.wrData;
    pa = s.wrAddr[PART_MSB:PART_LSB];
    srcMode = s.partMode[s.readAddr[PART_MSB:PART_LSB]];
    case (srcMode)
      RM_STATUS: srcData = s.statusWord;
      RM_ID: srcData = idData;
      RM_CFI: srcData = cfiData;
      default: srcData = arrayData;
    endcase
    if (noWrap) begin
      nextAddr = s.bAddr + 24'h000001;
    end else if (bl == BL_8) begin
      nextAddr = {s.bAddr[ADDR_W-1:3], s.bAddr[2:0] + 3'h1};
    end else begin
      nextAddr = {s.bAddr[ADDR_W-1:4], s.bAddr[3:0] + 4'h1};
    end
    latchClk = 1'b0;
    latchAdv = 1'b0;
    waitAct = 1'b0;

    if (!b.resetN) begin
      n = rst_state();
      n.abortOp = 1'b1;
    end else begin
      n.abortOp = 1'b0;
      n.clkPrev = b.burstClk;
      n.advPrev = b.addressValidN;
      n.wrPrev = wrAct;
      n.lowPower = b.chipSelectN & !opBusy;
      if (!b.addressValidN && !b.chipSelectN) begin
        n.addrHold = curAddr;
      end
      if (wrAct) begin
        n.wrData = b.dataIn;
        n.wrAddr = muxedBus ? s.addrHold : b.address;
      end

      // reads never touch the pending command; only a finished write does.
      if (wrEnd) begin
        case (s.cmdPend)
          PEND_CFG: begin
            n.cmdPend = PEND_NONE;
            if (code == CMD_CFG_RCR) begin
              n.read_config_register = s.wrAddr[15:0];
            end else if (code == CMD_CFG_ECR) begin
              n.ecr = s.wrAddr[15:0];
            end else if (code != CMD_LOCK && code != CMD_LOCKDOWN && code != CMD_CONFIRM) begin
              n.errSeq = 1'b1;
              n.errProg = 1'b1;
            end
          end
          PEND_WORD, PEND_OTP: begin
            n.cmdPend = PEND_NONE;
            n.prog.otp = (s.cmdPend == PEND_OTP);
            n.prog.req = 1'b1;
            n.prog.addr = s.wrAddr;
            n.prog.data = code;
            if (s.cmdPend == PEND_WORD) begin
              n.partMode[pa] = RM_STATUS;
            end
          end
          PEND_BUF: begin
            // Loading writes of a buffered program are passed on, not flagged.
            n.prog.addr = s.wrAddr;
            n.prog.data = code;
            if (code == CMD_CONFIRM) begin
              n.cmdPend = PEND_NONE;
              n.prog.bufStart = 1'b1;
              n.partMode[pa] = RM_STATUS;
            end else begin
              n.prog.bufData = 1'b1;
            end
          end
          default: begin
            case (code)
              CMD_CFG_SETUP: n.cmdPend = PEND_CFG;
              CMD_WORD_PROG: n.cmdPend = PEND_WORD;
              CMD_OTP: n.cmdPend = PEND_OTP;
              CMD_BUF_SETUP: n.cmdPend = PEND_BUF;
              CMD_CLR_STATUS: begin
                n.errSeq = 1'b0;
                n.errProg = 1'b0;
              end
              CMD_RD_ARRAY: n.partMode[pa] = RM_ARRAY;
              CMD_RD_STATUS: n.partMode[pa] = RM_STATUS;
              CMD_RD_ID: n.partMode[pa] = RM_ID;
              CMD_RD_CFI: n.partMode[pa] = RM_CFI;
              default: n.cmdPend = PEND_NONE;
            endcase
          end
        endcase
      end
      // An engine error arriving with a clear still lands.
      if (progError) begin
        n.errProg = 1'b1;
      end

      if (b.addressValidN || b.chipSelectN) begin
        n.advUsed = 1'b0;
      end
      if (syncMode && !b.chipSelectN) begin
        latchClk = clkRise & !b.addressValidN & (fastGrade | !s.advUsed);
        latchAdv = advRise & !s.advUsed & !fastGrade;
      end
      if (b.chipSelectN) begin
        n.bActive = 1'b0;
      end else if (latchClk || latchAdv) begin
        n.bActive = 1'b1;
        n.advUsed = 1'b1;
        n.bAddr = latchAdv ? s.addrHold : curAddr;
        n.bStartOdd = (n.bAddr[3:0] != 4'h0);
        n.latCnt = lat;
        n.eowCnt = 4'h0;
        n.eowDone = 1'b0;
        n.bRemain = (bl == BL_8) ? LEN_8 : LEN_16;
      end else if (s.bActive && clkRise) begin
        if (s.latCnt > 4'h1) begin
          n.latCnt = s.latCnt - 4'h1;
        end else if (s.eowCnt > 4'h1) begin
          n.eowCnt = s.eowCnt - 4'h1;
        end else if (cont || s.bRemain != 5'h00) begin
          n.latCnt = 4'h0;
          n.eowCnt = 4'h0;
          n.pins.dataOut = srcData;
          if (!cont) begin
            n.bRemain = s.bRemain - 5'h01;
          end
          if (srcMode == RM_ARRAY) begin
            n.bAddr = nextAddr;
            if (noWrap && s.bStartOdd && !s.eowDone && s.bAddr[3:0] == 4'hf) begin
              // Loaded with the latency so the line-end word still shows as valid.
              n.eowCnt = lat;
              n.eowDone = 1'b1;
            end
          end
        end
      end

      n.readAddr = (syncMode && n.bActive) ? n.bAddr : rdAddr;
      if (!syncMode) begin
        n.pins.dataOut = srcData;
      end
      n.pins.dataOe = rdSel;
      n.pins.waitOe = !b.chipSelectN & (rdSel | muxedBus);
      waitAct = syncMode & rdSel & n.bActive
        & (n.latCnt != 4'h0 || (n.eowCnt != 4'h0 && n.eowCnt != lat));
      n.pins.waitOut = ~(waitAct ^ s.read_config_register[RCR_WAITPOL_BIT]);
      n.statusWord = '0;
      n.statusWord[SR_READY_BIT] = !opBusy;
      n.statusWord[SR_ESEQ_BIT] = n.errSeq;
      n.statusWord[SR_EPROG_BIT] = n.errProg;
    end
    state_next = n;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= rst_state();
    end else begin
      state_reg <= state_next;
    end
  end

  assign pinOut = state_reg.pins;
  assign prog = state_reg.prog;
  assign readAddr = state_reg.readAddr;
  assign abortOp = state_reg.abortOp;
  assign readConfig = state_reg.read_config_register;
  assign extConfig = state_reg.ecr;
  assign statusWord = state_reg.statusWord;
  assign lowPower = state_reg.lowPower;

endmodule

//--- fbi_flash_bus_monitor.sv
// Checker of the flash bus front end, bound to its ports.
`timescale 1ns/1ps
module fbi_flash_bus_monitor
  import fbi_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Pins and straps
  input wire fbi_bus_in_s busIn,
  input wire logic muxedBus,
  input wire logic fastGrade,
  input wire fbi_pin_out_s pinOut,
  // Sources and engine
  input wire logic [ADDR_W-1:0] readAddr,
  input wire logic [DATA_W-1:0] arrayData,
  input wire logic [DATA_W-1:0] idData,
  input wire logic [DATA_W-1:0] cfiData,
  input wire logic opBusy,
  input wire logic progError,
  input wire fbi_prog_s prog,
  input wire logic abortOp,
  // Configuration and status
  input wire logic [15:0] readConfig,
  input wire logic [15:0] extConfig,
  input wire logic [15:0] statusWord,
  input wire logic lowPower
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  chk_standby_quiet: assert property (busIn.resetN && busIn.chipSelectN |=> !pinOut.dataOe)
    else $error("Data driven in standby.");
  chk_power_drop: assert property (busIn.resetN && busIn.chipSelectN && !opBusy |=> lowPower)
    else $error("No low power in idle standby.");
  chk_busy_awake: assert property (opBusy |=> !lowPower)
    else $error("Low power while busy.");
  chk_outdis_quiet: assert property (busIn.resetN && !busIn.chipSelectN && busIn.outputEnableN
    && !muxedBus |=> !pinOut.dataOe && !pinOut.waitOe)
    else $error("Pins driven with output enable high.");
  chk_async_addr: assert property (readConfig[RCR_MODE_BIT] && busIn.resetN && !muxedBus
    && !busIn.chipSelectN && !busIn.outputEnableN && busIn.writeEnableN
    && !busIn.addressValidN |=> readAddr == $past(busIn.address) && pinOut.dataOe)
    else $error("Read address or enable wrong.");
  chk_pin_reset: assert property (!busIn.resetN |=> abortOp && !pinOut.dataOe
    && readConfig == RCR_RESET)
    else $error("Pin reset state wrong.");
  chk_abort_release: assert property (busIn.resetN |=> !abortOp)
    else $error("Abort held after pin reset.");
  chk_seq_bits: assert property ($rose(statusWord[SR_ESEQ_BIT]) |-> statusWord[SR_EPROG_BIT])
    else $error("Sequence error without bit four.");
  chk_prog_pulse: assert property (prog.req |=> !prog.req)
    else $error("Program request longer than one cycle.");
  cover property (prog.req && prog.otp);
  cover property ($rose(statusWord[SR_ESEQ_BIT]));
  cover property (lowPower);
  cover property (pinOut.waitOe && pinOut.waitOut);
endmodule

//--- fbi_host_model.sv
// Host controller model driving the flash bus pins.
`timescale 1ns/1ps
module fbi_host_model
  import fbi_pkg::*;
(
  // Clock
  input wire logic clk,
  // Flash bus pins
  output fbi_bus_in_s busIn
);
  event done;
  event beat;
  initial busIn = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 24'h0, 16'h0};
  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    @(posedge clk);
    busIn <= '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, a, d};
    @(posedge clk);
    // A released data line shows the inverse, never a stale value.
    busIn <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, a, ~d};
  endtask
  task automatic rd(input logic [23:0] a);
    @(posedge clk);
    busIn <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, a, busIn.dataIn};
    repeat (3) @(posedge clk);
    #1 -> done;
  endtask
  // burst with address valid held low
  task automatic burst(input logic [23:0] a, input int n);
    @(posedge clk);
    busIn <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, a, busIn.dataIn};
    repeat (n) begin
      @(posedge clk);
      busIn.burstClk <= 1'b1;
      @(posedge clk);
      busIn.burstClk <= 1'b0;
      #1 -> beat;
    end
  endtask
  task automatic idle();
    @(posedge clk);
    busIn <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, busIn.address, ~busIn.dataIn};
  endtask
  task automatic pinReset();
    @(posedge clk);
    busIn.resetN <= 1'b0;
    repeat (3) @(posedge clk);
    busIn.resetN <= 1'b1;
    #1;
  endtask
endmodule

//--- flash_bus_interface_cmd_tb.sv
// Self-checking bench of the flash bus front end.
`timescale 1ns/1ps
`define CK(g, e) begin nChecks++; if ((g) !== (e)) begin nMismatch++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module flash_bus_interface_cmd_tb
  import fbi_pkg::*;
;
  logic clk, reset, opBusy, abortOp, lowPower;
  fbi_bus_in_s busIn;
  fbi_pin_out_s pinOut;
  fbi_prog_s prog;
  logic [23:0] readAddr, a;
  logic [15:0] arrayData, idData, cfiData, readConfig, extConfig, statusWord, d;
  logic [15:0] codes[4] = '{CMD_RD_ARRAY, CMD_RD_ID, CMD_RD_CFI, CMD_RD_STATUS};
  logic [40:0] expQ[$];
  logic [17:0] beatQ[$];
  logic [31:0] seed = 32'd43548;
  int nMismatch = 0;
  int nChecks = 0;
  assign arrayData = readAddr[15:0] ^ 16'h5a5a;
  assign idData = readAddr[15:0] + 16'h1234;
  assign cfiData = ~readAddr[15:0];
  fbi_host_model fbi_host_model_i (.clk(clk), .busIn(busIn));
  fbi_flash_bus fbi_flash_bus_i (.clk(clk), .reset(reset), .busIn(busIn), .muxedBus(1'b0),
    .fastGrade(1'b0), .pinOut(pinOut), .readAddr(readAddr), .arrayData(arrayData),
    .idData(idData), .cfiData(cfiData), .opBusy(opBusy), .progError(1'b0), .prog(prog),
    .abortOp(abortOp), .readConfig(readConfig), .extConfig(extConfig),
    .statusWord(statusWord), .lowPower(lowPower));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic rdx(input logic [23:0] ad, input logic [15:0] e, input bit rel = 1'b1);
    expQ.push_back({25'h0, e});
    fbi_host_model_i.rd(ad);
    if (rel) fbi_host_model_i.idle();
  endtask
  task automatic bst(input logic [15:0] cfg, input bit wrap);
    logic [23:0] s;
    logic [15:0] w;
    int j;
    s = {3'h0, 17'(rnd()), 4'he};
    fbi_host_model_i.wr({8'h00, cfg}, CMD_CFG_SETUP);
    fbi_host_model_i.wr({8'h00, cfg}, CMD_CFG_RCR);
    for (int k = 0; k < 7; k++) begin
      j = (k < 2) ? 0 : (wrap || k < 4) ? k - 2 : k - 3;
      w = wrap ? {s[15:3], s[2:0] + 3'(j)} : s[15:0] + 16'(j);
      beatQ.push_back({k >= 2, k < 2 || (!wrap && k == 4), w ^ 16'h5a5a});
    end
    fbi_host_model_i.burst(s, 7);
    fbi_host_model_i.idle();
  endtask
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", nChecks, nMismatch);
    if (nMismatch == 0 && nChecks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    if (prog.req) begin
      `CK({prog.otp, prog.addr, prog.data}, expQ.pop_front())
    end
  end
  always @(fbi_host_model_i.done) begin
    `CK({25'h0, pinOut.dataOut}, expQ.pop_front())
  end
  always @(fbi_host_model_i.beat) begin
    logic [17:0] bt;
    bt = beatQ.pop_front();
    `CK(pinOut.waitOut, bt[16])
    if (bt[17]) `CK(pinOut.dataOut, bt[15:0])
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    nMismatch++;
    print_verdict();
  end
  initial begin
    reset = 1'b1;
    opBusy = 1'b0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    `CK(readConfig, RCR_RESET)
    a = {3'h0, 21'(rnd())};
    rdx(a, a[15:0] ^ 16'h5a5a, 1'b0);
    a[3:0] = ~a[3:0];
    rdx(a, a[15:0] ^ 16'h5a5a);
    for (int i = 0; i < 4; i++) begin
      a = {3'h5, 21'(rnd())};
      fbi_host_model_i.wr(a, codes[i]);
      d = (i == 0) ? a[15:0] ^ 16'h5a5a : (i == 1) ? a[15:0] + 16'h1234 :
        (i == 2) ? ~a[15:0] : 16'h0080;
      rdx(a, d);
    end
    // Reads between setup and a stray code must not disturb the pending command.
    fbi_host_model_i.wr(a, CMD_CFG_SETUP);
    rdx(a, 16'h0080);
    fbi_host_model_i.wr(a, CMD_RD_STATUS);
    rdx(a, 16'h00b0);
    fbi_host_model_i.wr(a, CMD_CLR_STATUS);
    rdx(a, 16'h0080);
    d = 16'(rnd());
    d[RCR_MODE_BIT] = 1'b1;
    fbi_host_model_i.wr({8'h00, d}, CMD_CFG_SETUP);
    fbi_host_model_i.wr({8'h00, d}, CMD_CFG_RCR);
    repeat (2) @(posedge clk);
    #1;
    `CK(readConfig, d)
    d = 16'(rnd());
    fbi_host_model_i.wr({8'h00, d}, CMD_CFG_SETUP);
    fbi_host_model_i.wr({8'h00, d}, CMD_CFG_ECR);
    repeat (2) @(posedge clk);
    #1;
    `CK(extConfig, d)
    a = {3'h2, 21'(rnd())};
    d = 16'(rnd());
    fbi_host_model_i.wr(a, CMD_WORD_PROG);
    expQ.push_back({1'b0, a, d});
    fbi_host_model_i.wr(a, d);
    repeat (3) @(posedge clk);
    rdx(a, 16'h0080);
    fbi_host_model_i.wr(a, CMD_OTP);
    expQ.push_back({1'b1, a, d});
    fbi_host_model_i.wr(a, d);
    repeat (3) @(posedge clk);
    opBusy <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CK(lowPower, 1'b0)
    `CK(pinOut.dataOe, 1'b0)
    @(posedge clk);
    opBusy <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    `CK(lowPower, 1'b1)
    fbi_host_model_i.pinReset();
    `CK(abortOp, 1'b1)
    `CK(readConfig, RCR_RESET)
    rdx(a, a[15:0] ^ 16'h5a5a);
    fbi_host_model_i.wr(a, CMD_BUF_SETUP);
    fbi_host_model_i.wr(a, d);
    fbi_host_model_i.wr(a, CMD_CONFIRM);
    rdx(a, 16'h0080);
    // Latency two, wait high true, no wrap, continuous: one line-end stall.
    bst(16'h140f, 1'b0);
    // Latency two, wait high true, wrap within eight words.
    bst(16'h1402, 1'b1);
    print_verdict();
  end
endmodule
bind fbi_flash_bus fbi_flash_bus_monitor fbi_flash_bus_monitor_i (.*);
